/* File: hdl/dir_entry_builder.sv */
// Directory entry builder: formats file entries into directory blocks for the recorder.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
module dir_entry_builder #(
	parameter int BLOCK_BYTES = 512,
	parameter int DIR_BLOCKS = 2,
	parameter logic [63:0] MEDIA_BLOCKS = 64'h0000_0000_0010_0000,
	parameter int NAME_DIGITS = 8
) (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic [dir_entry_pkg::REG_ADDR_W-1:0] ADDR_I,
	input wire logic [dir_entry_pkg::DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [dir_entry_pkg::DATA_W-1:0] RDATA_O,
	output logic BUSY_O
);
	import dir_entry_pkg::*;

	localparam int BLOCK_WORDS = BLOCK_BYTES / 4;
	localparam int EPB = (BLOCK_BYTES - HDR_BYTES) / ENTRY_BYTES;
	localparam int DEPTH = DIR_BLOCKS * BLOCK_WORDS;
	localparam int AW = $clog2(DEPTH);
	localparam logic [31:0] FIRST_DATA_BLOCK = 32'(DIR_BLOCKS + 1);

	typedef enum {S_CLEAR, S_IDLE, S_ENTRY, S_HEADER} state_type;

	// Word address of a word inside the directory image.
	function automatic logic [AW-1:0] word_addr(input int blk, input int off);
		int a;
		a = blk * BLOCK_WORDS + off;
		return a[AW-1:0];
	endfunction

	dir_ram_if #(.AW(AW)) ram();
	logic [63:0] name_now;

	// Software-written staging registers.
	logic [31:0] sw_count_q, sw_count_d;
	logic [31:0] sw_size_q, sw_size_d;
	logic [31:0] sw_date_q, sw_date_d;
	logic [31:0] sw_time_q, sw_time_d;
	logic [7:0] sw_type_q, sw_type_d;
	logic [15:0] sw_del_q, sw_del_d;
	logic [31:0] dir_addr_q, dir_addr_d;

	// Engine state.
	state_type state_q, state_d;
	logic [15:0] wcnt_q, wcnt_d;
	logic [15:0] wlast_q, wlast_d;
	logic [7:0] ent_blk_q, ent_blk_d;
	logic [7:0] ent_slot_q, ent_slot_d;
	logic [7:0] cur_blk_q, cur_blk_d;
	logic [7:0] cur_slot_q, cur_slot_d;
	logic [7:0] last_blk_q, last_blk_d;
	logic [7:0] last_slot_q, last_slot_d;
	logic file_open_q, file_open_d;
	logic del_q, del_d;
	logic err_q, err_d;
	logic [31:0] next_free_q, next_free_d;
	logic [31:0] start_q, start_d;
	logic [31:0] count_q, count_d;
	logic [31:0] size_q, size_d;
	logic size_valid_q, size_valid_d;
	logic [31:0] date_q, date_d;
	logic [31:0] ctime_q, ctime_d;
	logic [31:0] close_q, close_d;
	logic [7:0] type_q, type_d;
	logic [63:0] name_q, name_d;

	// Bus-side output registers.
	logic [31:0] rdata_q, rdata_d;
	logic range_q, range_d;

	logic ctrl_wr;
	logic full;
	logic name_advance;
	logic name_restart;
	logic [15:0] hdr_count;
	logic [31:0] ent_word;
	logic [63:0] date_asc, ctime_asc, close_asc;
	logic [63:0] open_end;
	logic [63:0] size_limit;
	logic del_ok;

	dir_word_ram #(.DEPTH(DEPTH), .AW(AW)) u_store (
		.clk_i(CLK_I),
		.reset_n_i(RESET_N_I),
		.ram(ram.store)
	);

	dir_name_gen #(.DIGITS(NAME_DIGITS)) u_names (
		.clk_i(CLK_I),
		.reset_n_i(RESET_N_I),
		.restart_i(name_restart),
		.advance_i(name_advance),
		.name_o(name_now)
	);

	// Decoded conditions shared by the command checks.
	assign ctrl_wr = WR_I && (ADDR_I == REG_CTRL);
	assign full = (int'(cur_blk_q) >= DIR_BLOCKS);
	assign open_end = {32'h0000_0000, next_free_q} + {32'h0000_0000, sw_count_q};
	assign size_limit = {32'h0000_0000, count_q} * 64'(BLOCK_BYTES);
	// Full blocks before the current one hold the whole per-block entry count.
	assign hdr_count = (ent_blk_q < cur_blk_q) ? 16'(EPB) : {8'h00, cur_slot_q};
	assign del_ok = ((sw_del_q[15:8] < cur_blk_q) && (int'(sw_del_q[7:0]) < EPB))
		|| ((sw_del_q[15:8] == cur_blk_q) && (sw_del_q[7:0] < cur_slot_q));
	assign date_asc = digits_to_ascii(date_q);
	assign ctime_asc = digits_to_ascii(ctime_q);
	assign close_asc = digits_to_ascii(close_q);

	// Entry word source; every field is big-endian with its top byte in the word's top byte.
	always_comb begin
		case (int'(wcnt_q))
			W_NAME: ent_word = name_q[63:32];
			W_NAME + 1: ent_word = name_q[31:0];
			W_START: ent_word = 32'h0000_0000;
			W_START + 1: ent_word = start_q;
			W_COUNT: ent_word = 32'h0000_0000;
			W_COUNT + 1: ent_word = del_q ? 32'h0000_0000 : count_q;
			W_SIZE: ent_word = size_valid_q ? 32'h0000_0000 : WORD_FF;
			W_SIZE + 1: ent_word = size_valid_q ? size_q : WORD_FF;
			W_DATE: ent_word = date_asc[63:32];
			W_DATE + 1: ent_word = date_asc[31:0];
			W_CTIME: ent_word = ctime_asc[63:32];
			W_CTIME + 1: ent_word = ctime_asc[31:0];
			W_TYPE: ent_word = {type_q, FILL_FF, FILL_FF, FILL_FF};
			W_RSVD: ent_word = WORD_FF;
			W_CLOSE: ent_word = close_asc[63:32];
			W_CLOSE + 1: ent_word = close_asc[31:0];
			default: ent_word = {NAME_PAD, NAME_PAD, NAME_PAD, NAME_PAD};
		endcase
	end

	// Store port: the clear pass, entry writes and header count updates share one write port.
	always_comb begin
		ram.we = 1'b0;
		ram.waddr = '0;
		ram.wdata = WORD_FF;
		ram.raddr = dir_addr_q[AW-1:0];
		case (state_q)
			S_CLEAR: begin
				ram.we = 1'b1;
				ram.waddr = word_addr(int'(ent_blk_q), int'(wcnt_q));
				if (int'(wcnt_q) == HDR_W_COUNT) begin
					ram.wdata = {FILL_FF, FILL_FF, 16'h0000};
				end else if (int'(wcnt_q) == HDR_W_BSIZE) begin
					ram.wdata = 32'(BLOCK_BYTES);
				end else begin
					ram.wdata = WORD_FF;
				end
			end
			S_ENTRY: begin
				ram.we = 1'b1;
				ram.waddr = word_addr(int'(ent_blk_q), HDR_WORDS + int'(ent_slot_q) * ENTRY_WORDS + int'(wcnt_q));
				ram.wdata = ent_word;
			end
			S_HEADER: begin
				ram.we = 1'b1;
				ram.waddr = word_addr(int'(ent_blk_q), HDR_W_COUNT);
				ram.wdata = {FILL_FF, FILL_FF, hdr_count};
			end
			default: begin
				ram.we = 1'b0;
			end
		endcase
	end

	// Software staging registers take plain writes.
	always_comb begin
		sw_count_d = sw_count_q;
		sw_size_d = sw_size_q;
		sw_date_d = sw_date_q;
		sw_time_d = sw_time_q;
		sw_type_d = sw_type_q;
		sw_del_d = sw_del_q;
		dir_addr_d = dir_addr_q;
		if (WR_I) begin
			case (ADDR_I)
				REG_BLOCK_COUNT: sw_count_d = WDATA_I;
				REG_BYTE_LENGTH: sw_size_d = WDATA_I;
				REG_DATE: sw_date_d = WDATA_I;
				REG_TIME: sw_time_d = WDATA_I;
				REG_TIME_TYPE: sw_type_d = WDATA_I[7:0];
				REG_DELETE_SEL: sw_del_d = WDATA_I[15:0];
				REG_DIR_ADDR: dir_addr_d = WDATA_I;
				default: sw_count_d = sw_count_q;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			sw_count_q <= 32'h0000_0000;
			sw_size_q <= 32'h0000_0000;
			sw_date_q <= NO_DIGITS;
			sw_time_q <= NO_DIGITS;
			sw_type_q <= TIME_SYSTEM;
			sw_del_q <= 16'h0000;
			dir_addr_q <= 32'h0000_0000;
		end else begin
			sw_count_q <= sw_count_d;
			sw_size_q <= sw_size_d;
			sw_date_q <= sw_date_d;
			sw_time_q <= sw_time_d;
			sw_type_q <= sw_type_d;
			sw_del_q <= sw_del_d;
			dir_addr_q <= dir_addr_d;
		end
	end

	// Engine: clear pass after reset or init, then open, close and delete commands.
	always_comb begin
		state_d = state_q;
		wcnt_d = wcnt_q;
		wlast_d = wlast_q;
		ent_blk_d = ent_blk_q;
		ent_slot_d = ent_slot_q;
		cur_blk_d = cur_blk_q;
		cur_slot_d = cur_slot_q;
		last_blk_d = last_blk_q;
		last_slot_d = last_slot_q;
		file_open_d = file_open_q;
		del_d = del_q;
		err_d = err_q;
		next_free_d = next_free_q;
		start_d = start_q;
		count_d = count_q;
		size_d = size_q;
		size_valid_d = size_valid_q;
		date_d = date_q;
		ctime_d = ctime_q;
		close_d = close_q;
		type_d = type_q;
		name_d = name_q;
		name_advance = 1'b0;
		name_restart = 1'b0;
		case (state_q)
			S_CLEAR: begin
				wcnt_d = wcnt_q + 16'h0001;
				if (int'(wcnt_q) == BLOCK_WORDS - 1) begin
					wcnt_d = 16'h0000;
					ent_blk_d = ent_blk_q + 8'h01;
					if (int'(ent_blk_q) == DIR_BLOCKS - 1) begin
						state_d = S_IDLE;
					end
				end
			end
			S_ENTRY: begin
				wcnt_d = wcnt_q + 16'h0001;
				if (wcnt_q == wlast_q) begin
					state_d = (wlast_q == 16'(ENTRY_WORDS - 1) && !del_q && file_open_q) ? S_HEADER : S_IDLE;
				end
			end
			S_HEADER: begin
				state_d = S_IDLE;
			end
			default: begin
				if (ctrl_wr && WDATA_I[CTRL_INIT]) begin
					// A fresh directory forgets every entry and restarts names and allocation.
					state_d = S_CLEAR;
					wcnt_d = 16'h0000;
					ent_blk_d = 8'h00;
					cur_blk_d = 8'h00;
					cur_slot_d = 8'h00;
					file_open_d = 1'b0;
					next_free_d = FIRST_DATA_BLOCK;
					name_restart = 1'b1;
					err_d = 1'b0;
				end else if (ctrl_wr && WDATA_I[CTRL_OPEN]) begin
					// Only valid qualifiers are written; a reserved code refuses the open.
					if (file_open_q || full || sw_count_q == 32'h0000_0000 || open_end > MEDIA_BLOCKS
						|| (sw_type_q != TIME_UTC && sw_type_q != TIME_SYSTEM && sw_type_q != TIME_PACKET)) begin
						err_d = 1'b1;
					end else begin
						err_d = 1'b0;
						// Blocks are handed out from a rising pointer and reused only after an init or a reset, so ranges never meet.
						start_d = next_free_q;
						next_free_d = next_free_q + sw_count_q;
						count_d = sw_count_q;
						size_valid_d = 1'b0;
						date_d = sw_date_q;
						ctime_d = sw_time_q;
						close_d = NO_DIGITS;
						type_d = sw_type_q;
						name_d = name_now;
						name_advance = 1'b1;
						ent_blk_d = cur_blk_q;
						ent_slot_d = cur_slot_q;
						last_blk_d = cur_blk_q;
						last_slot_d = cur_slot_q;
						if (int'(cur_slot_q) == EPB - 1) begin
							cur_slot_d = 8'h00;
							cur_blk_d = cur_blk_q + 8'h01;
						end else begin
							cur_slot_d = cur_slot_q + 8'h01;
						end
						file_open_d = 1'b1;
						del_d = 1'b0;
						wcnt_d = 16'(W_NAME);
						wlast_d = 16'(ENTRY_WORDS - 1);
						state_d = S_ENTRY;
					end
				end else if (ctrl_wr && WDATA_I[CTRL_CLOSE]) begin
					if (!file_open_q || (WDATA_I[CTRL_SIZE_VALID] && {32'h0000_0000, sw_size_q} > size_limit)) begin
						err_d = 1'b1;
					end else begin
						err_d = 1'b0;
						size_valid_d = WDATA_I[CTRL_SIZE_VALID];
						size_d = sw_size_q;
						close_d = sw_time_q;
						ent_blk_d = last_blk_q;
						ent_slot_d = last_slot_q;
						del_d = 1'b0;
						file_open_d = 1'b0;
						wcnt_d = 16'(W_SIZE);
						wlast_d = 16'(ENTRY_WORDS - 1);
						state_d = S_ENTRY;
					end
				end else if (ctrl_wr && WDATA_I[CTRL_DELETE]) begin
					if (!del_ok) begin
						err_d = 1'b1;
					end else begin
						// The slot keeps its place, so the block's entry count does not drop.
						err_d = 1'b0;
						ent_blk_d = sw_del_q[15:8];
						ent_slot_d = sw_del_q[7:0];
						del_d = 1'b1;
						if (sw_del_q[15:8] == last_blk_q && sw_del_q[7:0] == last_slot_q) begin
							file_open_d = 1'b0;
						end
						wcnt_d = 16'(W_COUNT);
						wlast_d = 16'(W_COUNT + 1);
						state_d = S_ENTRY;
					end
				end else if (ctrl_wr) begin
					err_d = err_q;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state_q <= S_CLEAR;
			wcnt_q <= 16'h0000;
			wlast_q <= 16'h0000;
			ent_blk_q <= 8'h00;
			ent_slot_q <= 8'h00;
			cur_blk_q <= 8'h00;
			cur_slot_q <= 8'h00;
			last_blk_q <= 8'h00;
			last_slot_q <= 8'h00;
			file_open_q <= 1'b0;
			del_q <= 1'b0;
			err_q <= 1'b0;
			next_free_q <= FIRST_DATA_BLOCK;
			start_q <= WORD_FF;
			count_q <= 32'h0000_0000;
			size_q <= 32'h0000_0000;
			size_valid_q <= 1'b0;
			date_q <= NO_DIGITS;
			ctime_q <= NO_DIGITS;
			close_q <= NO_DIGITS;
			type_q <= TIME_SYSTEM;
			name_q <= 64'h0000_0000_0000_0000;
		end else begin
			state_q <= state_d;
			wcnt_q <= wcnt_d;
			wlast_q <= wlast_d;
			ent_blk_q <= ent_blk_d;
			ent_slot_q <= ent_slot_d;
			cur_blk_q <= cur_blk_d;
			cur_slot_q <= cur_slot_d;
			last_blk_q <= last_blk_d;
			last_slot_q <= last_slot_d;
			file_open_q <= file_open_d;
			del_q <= del_d;
			err_q <= err_d;
			next_free_q <= next_free_d;
			start_q <= start_d;
			count_q <= count_d;
			size_q <= size_d;
			size_valid_q <= size_valid_d;
			date_q <= date_d;
			ctime_q <= ctime_d;
			close_q <= close_d;
			type_q <= type_d;
			name_q <= name_d;
		end
	end

	// Read data stand for one cycle only; outside reads the bus shows zero.
	always_comb begin
		rdata_d = 32'h0000_0000;
		range_d = range_q;
		if (RD_I) begin
			case (ADDR_I)
				REG_STATUS: rdata_d = {27'h0, range_q, full, err_q, file_open_q, state_q != S_IDLE};
				REG_BLOCK_COUNT: rdata_d = sw_count_q;
				REG_BYTE_LENGTH: rdata_d = sw_size_q;
				REG_DATE: rdata_d = sw_date_q;
				REG_TIME: rdata_d = sw_time_q;
				REG_TIME_TYPE: rdata_d = {24'h0, sw_type_q};
				REG_DELETE_SEL: rdata_d = {16'h0, sw_del_q};
				REG_DIR_ADDR: rdata_d = dir_addr_q;
				REG_DIR_DATA: begin
					// Past the image the word is zero and a sticky flag reports it.
					range_d = (dir_addr_q >= 32'(DEPTH));
					rdata_d = (dir_addr_q >= 32'(DEPTH)) ? 32'h0000_0000 : ram.rdata;
				end
				REG_ENTRY_INFO: rdata_d = {cur_blk_q, cur_slot_q, last_blk_q, last_slot_q};
				REG_NEXT_FREE: rdata_d = next_free_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rdata_q <= 32'h0000_0000;
			range_q <= 1'b0;
			BUSY_O <= 1'b1;
		end else begin
			rdata_q <= rdata_d;
			range_q <= range_d;
			BUSY_O <= (state_d != S_IDLE);
		end
	end

	assign RDATA_O = rdata_q;
endmodule

/* File: hdl/dir_entry_pkg.sv */
// Shared constants, field layout and digit encoding for the directory entry builder.
package dir_entry_pkg;

	// Register bus geometry.
	localparam int DATA_W = 32;
	localparam int REG_ADDR_W = 8;

	// Register byte addresses.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_BLOCK_COUNT = 8'h08;
	localparam logic [7:0] REG_BYTE_LENGTH = 8'h0C;
	localparam logic [7:0] REG_DATE = 8'h10;
	localparam logic [7:0] REG_TIME = 8'h14;
	localparam logic [7:0] REG_TIME_TYPE = 8'h18;
	localparam logic [7:0] REG_DELETE_SEL = 8'h1C;
	localparam logic [7:0] REG_DIR_ADDR = 8'h20;
	localparam logic [7:0] REG_DIR_DATA = 8'h24;
	localparam logic [7:0] REG_ENTRY_INFO = 8'h28;
	localparam logic [7:0] REG_NEXT_FREE = 8'h2C;

	// Command bits of the control register.
	localparam int CTRL_OPEN = 0;
	localparam int CTRL_CLOSE = 1;
	localparam int CTRL_DELETE = 2;
	localparam int CTRL_INIT = 3;
	localparam int CTRL_SIZE_VALID = 4;

	// Status bits.
	localparam int STAT_BUSY = 0;
	localparam int STAT_OPEN = 1;
	localparam int STAT_ERROR = 2;
	localparam int STAT_FULL = 3;
	localparam int STAT_RANGE = 4;

	// Directory block and entry geometry in bytes and words.
	localparam int HDR_BYTES = 64;
	localparam int ENTRY_BYTES = 112;
	localparam int HDR_WORDS = 16;
	localparam int ENTRY_WORDS = 28;
	localparam int HDR_W_COUNT = 2;
	localparam int HDR_W_BSIZE = 3;

	// Word index of each entry field inside one entry.
	localparam int W_NAME = 0;
	localparam int W_START = 14;
	localparam int W_COUNT = 16;
	localparam int W_SIZE = 18;
	localparam int W_DATE = 20;
	localparam int W_CTIME = 22;
	localparam int W_TYPE = 24;
	localparam int W_RSVD = 25;
	localparam int W_CLOSE = 26;

	// Fill values.
	localparam logic [7:0] FILL_FF = 8'hFF;
	localparam logic [7:0] NAME_PAD = 8'h00;
	localparam logic [7:0] DIGIT_FILL = 8'h2D;
	localparam logic [7:0] ASCII_ZERO = 8'h30;
	localparam logic [31:0] WORD_FF = 32'hFFFF_FFFF;
	localparam logic [31:0] NO_DIGITS = 32'hFFFF_FFFF;

	// Time qualifier codes.
	localparam logic [7:0] TIME_UTC = 8'h00;
	localparam logic [7:0] TIME_SYSTEM = 8'h01;
	localparam logic [7:0] TIME_PACKET = 8'hFF;

	// Turns eight packed decimal digits into eight ASCII bytes, first digit in the top byte.
	// A nibble above nine marks an unavailable digit and becomes the dash fill.
	function automatic logic [63:0] digits_to_ascii(input logic [31:0] bcd);
		logic [63:0] res;
		logic [3:0] nib;
		res = '0;
		for (int i = 0; i < 8; i++) begin
			nib = bcd[31 - 4 * i -: 4];
			res[63 - 8 * i -: 8] = (nib > 4'h9) ? DIGIT_FILL : (ASCII_ZERO + {4'h0, nib});
		end
		return res;
	endfunction

endpackage

/* File: hdl/dir_ram_if.sv */
// Port bundle between the entry builder and its directory word store.
`timescale 1ns/1ps
interface dir_ram_if #(parameter int AW = 8);
	logic we;
	logic [AW-1:0] waddr;
	logic [31:0] wdata;
	logic [AW-1:0] raddr;
	logic [31:0] rdata;
	modport owner(output we, output waddr, output wdata, output raddr, input rdata);
	modport store(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: hdl/dir_word_ram.sv */
// Directory image store: one write port, one read port with registered read data.
`timescale 1ns/1ps
module dir_word_ram #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	dir_ram_if.store ram
);
	logic [31:0] mem [DEPTH];
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// Out-of-range read addresses return zero rather than wrapping onto real entries.
	always_comb begin
		rdata_d = (int'(ram.raddr) < DEPTH) ? mem[ram.raddr] : 32'h0000_0000;
	end

	// The array itself has no reset; the clear pass fills it after reset.
	always_ff @(posedge clk_i) begin
		if (ram.we) begin
			mem[ram.waddr] <= ram.wdata;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign ram.rdata = rdata_q;
endmodule

/* File: hdl/dir_name_gen.sv */
// Default file name source: a decimal counter from one, shown as left-aligned ASCII.
`timescale 1ns/1ps
module dir_name_gen #(
	parameter int DIGITS = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic restart_i,
	input wire logic advance_i,
	output logic [63:0] name_o
);
	import dir_entry_pkg::*;

	logic [3:0] cnt_q [DIGITS];
	logic [3:0] cnt_d [DIGITS];
	logic carry;
	int used;

	// Decimal increment with carry; a restart returns the counter to one.
	always_comb begin
		carry = advance_i;
		for (int i = 0; i < DIGITS; i++) begin
			cnt_d[i] = cnt_q[i];
			if (carry) begin
				if (cnt_q[i] == 4'h9) begin
					cnt_d[i] = 4'h0;
				end else begin
					cnt_d[i] = cnt_q[i] + 4'h1;
					carry = 1'b0;
				end
			end
		end
		if (restart_i) begin
			for (int i = 0; i < DIGITS; i++) begin
				cnt_d[i] = (i == 0) ? 4'h1 : 4'h0;
			end
		end
	end

	// Leading zeros are dropped so that the name starts at byte 0, and the tail is zero padded.
	always_comb begin
		used = 1;
		name_o = '0;
		for (int i = 0; i < DIGITS; i++) begin
			if (cnt_q[i] != 4'h0) begin
				used = i + 1;
			end
		end
		for (int i = 0; i < DIGITS; i++) begin
			name_o[63 - 8 * i -: 8] = (i < used) ? (ASCII_ZERO + {4'h0, cnt_q[used - 1 - i]}) : NAME_PAD;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < DIGITS; i++) begin
				cnt_q[i] <= (i == 0) ? 4'h1 : 4'h0;
			end
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

/* File: tb/dir_entry_chk.sv */
// Port-level assertions for the directory entry builder.
`timescale 1ns/1ps
module dir_entry_chk (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic [dir_entry_pkg::REG_ADDR_W-1:0] ADDR_I,
	input wire logic [dir_entry_pkg::DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [dir_entry_pkg::DATA_W-1:0] RDATA_O,
	input wire logic BUSY_O
);
	import dir_entry_pkg::*;
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);
	// A control write is the only thing allowed to start an entry update.
	logic ctl;
	assign ctl = WR_I && (ADDR_I == REG_CTRL);
	a_read_idle_zero: assert property (!$past(RD_I) |-> RDATA_O == '0) else $error("read data outside slot");
	a_busy_cause: assert property ($rose(BUSY_O) |-> $past(ctl)) else $error("busy without command");
	a_open_span: assert property ($rose(BUSY_O) && $past(WDATA_I[3:0]) == 4'h1 |->
		BUSY_O[*8] ##21 BUSY_O ##1 !BUSY_O) else $error("open length wrong");
	a_close_span: assert property ($rose(BUSY_O) && $past(WDATA_I[3:0]) == 4'h2 |->
		BUSY_O[*8] ##1 BUSY_O[*2] ##1 !BUSY_O) else $error("close length wrong");
	a_delete_span: assert property ($rose(BUSY_O) && $past(WDATA_I[3:0]) == 4'h4 |->
		BUSY_O[*2] ##1 !BUSY_O) else $error("delete length wrong");
	// The busy bit read back must agree with the busy pin seen at the read edge.
	a_status_upper: assert property ($past(RD_I) && $past(ADDR_I) == REG_STATUS |->
		RDATA_O[31:5] == '0 && RDATA_O[STAT_BUSY] == $past(BUSY_O))
		else $error("status spare bits set");
	a_type_upper: assert property ($past(RD_I) && $past(ADDR_I) == REG_TIME_TYPE |-> RDATA_O[31:8] == '0)
		else $error("time type spare bits set");
	a_unmapped_zero: assert property ($past(RD_I) && $past(ADDR_I) > REG_NEXT_FREE |-> RDATA_O == '0)
		else $error("unmapped read not zero");
endmodule

/* File: tb/dir_reader_model.sv */
// Host reader model: register bus master that walks the directory image.
`timescale 1ns/1ps
module dir_reader_model (
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	output logic [7:0] addr_o,
	output logic [31:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	import dir_entry_pkg::*;
	initial begin
		addr_o = '0;
		wdata_o = '0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Write data flips once the strobe drops, so stale data is never mistaken for a write.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask
	// Any word may be fetched in any order; the whole 32-bit word arrives in a single read.
	task automatic rdir(input int w, output logic [31:0] d);
		wr(REG_DIR_ADDR, 32'(w));
		@(posedge clk_i);
		rd(REG_DIR_DATA, d);
	endtask
endmodule

/* File: tb/dir_entry_builder_tb.sv */
// Self-checking bench for the directory entry builder and its host reader model.
`timescale 1ns/1ps
module dir_entry_builder_tb;
	import dir_entry_pkg::*;
	typedef struct {int wa; logic [31:0] exp;} row_type;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] v;
	logic wr;
	logic rd;
	logic busy;
	int err_total = 0;
	int num_checks = 0;
	// Files one and two, the second closed without a size and then deleted.
	row_type rows [19] = '{'{2, 32'hFFFF_0002}, '{3, 32'h0000_0200}, '{16, 32'h3100_0000},
		'{29, 32'h0000_0000}, '{30, 32'h0000_0000}, '{31, 32'h0000_0003}, '{32, 32'h0000_0000},
		'{33, 32'h0000_0003}, '{35, 32'h0000_03E8}, '{36, 32'h3032_3039}, '{37, 32'h3230_3030},
		'{38, 32'h3132_3334}, '{39, 32'h3536_2D2D}, '{40, 32'h01FF_FFFF}, '{41, 32'hFFFF_FFFF},
		'{42, 32'h3233_3539}, '{43, 32'h3031_2D2D}, '{44, 32'h3200_0000}, '{86, 32'hFFFF_FFFF}};
	initial begin
		forever #5 clk = ~clk;
	end
	dir_entry_builder dir_entry_builder_i (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BUSY_O(busy));
	dir_reader_model dir_reader_model_i (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		dir_reader_model_i.wr(a, d);
	endtask
	task automatic rw(input int w, input logic [31:0] e);
		dir_reader_model_i.rdir(w, v);
		chk($sformatf("word %0d", w), e, v);
	endtask
	task automatic stat(input int b, input logic e);
		dir_reader_model_i.rd(REG_STATUS, v);
		chk($sformatf("status bit %0d", b), {31'b0, e}, {31'b0, v[b]});
	endtask
	// Bounded wait, so a stuck busy flag counts as a failed check instead of hanging the run.
	task automatic wait_idle();
		int n;
		n = 0;
		#1;
		while (busy !== 1'b0 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("busy", 32'h0, {31'b0, busy});
	endtask
	task automatic cmd(input logic [31:0] c);
		put(REG_CTRL, c);
		wait_idle();
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#500_000;
		err_total++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wait_idle();
		put(REG_DATE, 32'h0209_2000);
		put(REG_TIME_TYPE, 32'h0000_0001);
		put(REG_BLOCK_COUNT, 32'h0000_0003);
		put(REG_TIME, 32'h1234_56FF);
		cmd(32'h0000_0001);
		stat(STAT_OPEN, 1'b1);
		put(REG_TIME, 32'h2359_01FF);
		put(REG_BYTE_LENGTH, 32'h0000_03E8);
		cmd(32'h0000_0012);
		put(REG_BLOCK_COUNT, 32'h0000_0002);
		cmd(32'h0000_0001);
		cmd(32'h0000_0002);
		put(REG_DELETE_SEL, 32'h0000_0001);
		cmd(32'h0000_0004);
		foreach (rows[i]) rw(rows[i].wa, rows[i].exp);
		rw(59, 32'h0000_0006);
		rw(61, 32'h0000_0000);
		rw(62, 32'hFFFF_FFFF);
		// Refused commands: reserved time type, double open, oversized close.
		put(REG_TIME_TYPE, 32'h0000_0002);
		put(REG_BLOCK_COUNT, 32'h0000_0001);
		cmd(32'h0000_0001);
		stat(STAT_ERROR, 1'b1);
		put(REG_TIME_TYPE, 32'h0000_0000);
		cmd(32'h0000_0001);
		stat(STAT_ERROR, 1'b0);
		cmd(32'h0000_0001);
		stat(STAT_ERROR, 1'b1);
		put(REG_BYTE_LENGTH, 32'h0000_0201);
		cmd(32'h0000_0012);
		stat(STAT_ERROR, 1'b1);
		cmd(32'h0000_0002);
		rw(96, 32'h00FF_FFFF);
		rw(87, 32'h0000_0008);
		// Fill the primary block and spill into the secondary one.
		put(REG_TIME_TYPE, 32'h0000_00FF);
		for (int i = 4; i <= 8; i++) begin
			cmd(32'h0000_0001);
			cmd(32'h0000_0002);
		end
		rw(124, 32'hFFFF_FFFF);
		rw(144, 32'h3500_0000);
		rw(159, 32'h0000_000A);
		rw(130, 32'hFFFF_0004);
		stat(STAT_FULL, 1'b1);
		cmd(32'h0000_0001);
		stat(STAT_ERROR, 1'b1);
		dir_reader_model_i.rd(8'h40, v);
		chk("unmapped", 32'h0, v);
		dir_reader_model_i.rd(REG_ENTRY_INFO, v);
		chk("entry info", 32'h0200_0103, v);
		dir_reader_model_i.rd(REG_NEXT_FREE, v);
		chk("next free", 32'h0000_000E, v);
		// A word past the image reads zero and raises the sticky flag until an in-range read.
		rw(300, 32'h0000_0000);
		stat(STAT_RANGE, 1'b1);
		rw(130, 32'hFFFF_0004);
		stat(STAT_RANGE, 1'b0);
		// A fresh directory wipes every entry and restarts allocation and names.
		cmd(32'h0000_0008);
		rw(31, 32'hFFFF_FFFF);
		rw(2, 32'hFFFF_0000);
		stat(STAT_FULL, 1'b0);
		put(REG_BLOCK_COUNT, 32'h0000_0001);
		cmd(32'h0000_0001);
		rw(16, 32'h3100_0000);
		rw(31, 32'h0000_0003);
		// Reset in mid-run with a file open must leave a clean empty directory.
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		wait_idle();
		stat(STAT_OPEN, 1'b0);
		rw(31, 32'hFFFF_FFFF);
		dir_reader_model_i.rd(REG_NEXT_FREE, v);
		chk("next free", 32'h0000_0003, v);
		conclude();
	end
endmodule
bind dir_entry_builder dir_entry_chk dir_entry_chk_i (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .BUSY_O(BUSY_O));
